/* logic/dbgbk_pkg.sv */
// Constants for the debug base pointer and banked data windows.
// Assumes a single port clock domain shared with the memory side.

`default_nettype none

package dbgbk_pkg;

  // Register offsets within the access port space
  localparam logic [7:0] OFS_WIN0      = 8'h10;
  localparam logic [7:0] OFS_WIN1      = 8'h14;
  localparam logic [7:0] OFS_WIN2      = 8'h18;
  localparam logic [7:0] OFS_WIN3      = 8'h1c;
  localparam logic [7:0] OFS_PTR_UPPER = 8'hf0;
  localparam logic [7:0] OFS_PTR_LOWER = 8'hf8;

  // Window group decode: offset bits 7:4 select the window block
  localparam logic [3:0] WIN_GROUP     = 4'h1;

  // Lower pointer word field positions
  localparam int PTR_PRESENT_BIT = 0;
  localparam int PTR_FORMAT_BIT  = 1;
  localparam int PTR_RSV_LSB     = 2;
  localparam int PTR_RSV_MSB     = 11;
  localparam int PTR_ADDR_LSB    = 12;
  localparam int PTR_DEDIC_BIT   = 31;

  // Fixed field values
  localparam logic [11:0] PTR_LOW_PAD   = 12'h000;
  localparam logic [9:0]  PTR_RSV_VAL   = 10'h000;
  localparam logic        PTR_FORMAT    = 1'h1;
  localparam logic [3:0]  ALIGN_PAD     = 4'h0;

  // Access size codes
  localparam logic [2:0] SIZE_WORD  = 3'h2;
  localparam logic [2:0] SIZE_DWORD = 3'h3;

  // Reset values
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;
  localparam logic [63:0] ADDR_RST  = 64'h0000_0000_0000_0000;
  localparam logic [63:0] WDATA_RST = 64'h0000_0000_0000_0000;

  typedef enum logic [1:0] {ST_IDLE, ST_MEM} dbgbk_state_t;

endpackage

`default_nettype wire

/* logic/dbgbk_top.sv */
// Debug base pointer words and the four banked data windows.
// Assumes the transfer address, size and control-word touch come from
// neighbouring port logic on CLK; memory side answers with a one-cycle ack.

`timescale 1ns/100ps
`default_nettype none

// Behaviour
// R1 - Lower pointer bit 1 reads one
// R2 - Address field is upper bits, low twelve zero
// R3 - Upper pointer word zero without wide addressing
// R4 - Lower pointer bits 11:2 read zero
// R5 - Bit 0 flags debug entry present
// R6 - Single component: base is its ID page
// R7 - Several components: base is lookup table
// R8 - Older pointer layout never presented
// R9 - Debugger decodes older layout itself
// R10 - Windows map to four words, address unchanged
// R11 - Windows never increment the transfer address
// R12 - Narrow address: aligned address plus window offset
// R13 - Wide address: 64-bit aligned plus offset
// R14 - Word bits 1:0 zero, doubleword 2:0
// R15 - Port access completes after memory access
// R16 - Lower window low word, higher high
// R17 - Debugger accesses lower window first
// R18 - Debugger uses only word or doubleword
// R19 - Each window carries 32-bit data
// R20 - Pointer read-only at 0xF8 and 0xF0
// R21 - Dedicated link forces address top bit; the code forces bit 31 only with narrow addressing
// R22 - Cut-short doubleword write starts nothing
// R23 - Doubleword read: one memory read, upper captured
module dbgbk_top #(
  parameter bit          LARGE_ADDR    = 1'b1,
  parameter bit          LARGE_DATA    = 1'b1,
  parameter bit          DEDICATED     = 1'b0,
  parameter bit          ENTRY_PRESENT = 1'b1,
  parameter logic [63:0] BASE_ADDR     = 64'h0000_0000_e00f_f000
) (
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        ARST_N,
  // Register access from the debug port
  input  wire logic        REQ_VALID,
  input  wire logic        REQ_WRITE,
  input  wire logic [7:0]  REQ_ADDR,
  input  wire logic [31:0] REQ_WDATA,
  output var  logic        REQ_READY,
  output var  logic        RSP_DONE,
  output var  logic [31:0] RSP_RDATA,
  // Neighbouring port state
  input  wire logic [63:0] TRANSFER_ADDRESS,
  input  wire logic [2:0]  ACCESS_SIZE,
  input  wire logic        CONTROL_STATUS_TOUCH,
  // Memory side
  output var  logic        MEM_REQ,
  output var  logic        MEM_WRITE,
  output var  logic [63:0] MEM_ADDR,
  output var  logic [2:0]  MEM_SIZE,
  output var  logic [63:0] MEM_WDATA,
  input  wire logic        MEM_ACK,
  input  wire logic [63:0] MEM_RDATA
);

  // Pointer value as presented; with narrow addressing the dedicated link forces bit 31
  localparam logic [63:0] BASE_EFF = {
    LARGE_ADDR ? BASE_ADDR[63:32] : 32'h0000_0000,
    BASE_ADDR[31] | (DEDICATED & ~LARGE_ADDR),
    BASE_ADDR[30:12], dbgbk_pkg::PTR_LOW_PAD};

  // Memory address for a window; the transfer address is only read here
  function automatic logic [63:0] win_addr(
    input logic [63:0] xfer,
    input logic [1:0]  idx,
    input logic        dw
  );
    logic [63:0] a;
    a = {xfer[63:4], dbgbk_pkg::ALIGN_PAD};                // R10 R11
    if (!LARGE_ADDR) begin
      a[63:32] = 32'h0000_0000;                             // R12
    end
    a[3:2] = dw ? {idx[1], 1'b0} : idx;                     // R13 R14
    return a;
  endfunction

  // Read value of a non-window register
  function automatic logic [31:0] ptr_read(input logic [7:0] ofs);
    logic [31:0] v;
    v = dbgbk_pkg::RDATA_RST;
    if (ofs == dbgbk_pkg::OFS_PTR_LOWER) begin
      v[31:dbgbk_pkg::PTR_ADDR_LSB] = BASE_EFF[31:12];      // R2 R6 R7 R21
      v[dbgbk_pkg::PTR_RSV_MSB:dbgbk_pkg::PTR_RSV_LSB] =
        dbgbk_pkg::PTR_RSV_VAL;                             // R4
      v[dbgbk_pkg::PTR_FORMAT_BIT] = dbgbk_pkg::PTR_FORMAT; // R1 R8
      v[dbgbk_pkg::PTR_PRESENT_BIT] = ENTRY_PRESENT;        // R5
    end else if (ofs == dbgbk_pkg::OFS_PTR_UPPER) begin
      v = BASE_EFF[63:32];                                  // R3 R20
    end
    return v;
  endfunction

  dbgbk_pkg::dbgbk_state_t state_r;
  logic        ready_r;
  logic        rsp_done_r;
  logic [31:0] rsp_rdata_r;
  logic        mem_req_r;
  logic        mem_write_r;
  logic [63:0] mem_addr_r;
  logic [2:0]  mem_size_r;
  logic [63:0] mem_wdata_r;
  logic        pend_r;
  logic        pend_pair_r;
  logic        pend_rd_r;
  logic [31:0] pend_word_r;
  logic        mem_dw_rd_r;

  // Request classification
  logic       take;
  logic       is_win;
  logic [1:0] idx;
  logic       dw;
  logic       pair_ok;
  logic       go_mem;
  logic       first_half;
  logic       second_half;

  always_comb begin
    take        = REQ_VALID && ready_r;
    is_win      = REQ_ADDR[7:4] == dbgbk_pkg::WIN_GROUP;
    idx         = REQ_ADDR[3:2];
    dw          = LARGE_DATA && ACCESS_SIZE == dbgbk_pkg::SIZE_DWORD; // R18
    pair_ok     = pend_r && pend_pair_r == idx[1]
                  && pend_rd_r == !REQ_WRITE;               // R17
    first_half  = is_win && dw && !idx[0];
    second_half = is_win && dw && idx[0];
    go_mem      = is_win && (!dw || (first_half && !REQ_WRITE)
                  || (second_half && REQ_WRITE && pair_ok)); // R22 R23
  end

  // Sequencing of port access and memory access
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_r <= dbgbk_pkg::ST_IDLE;
      ready_r <= 1'b1;
    end else if (state_r == dbgbk_pkg::ST_IDLE) begin
      if (take && go_mem) begin
        state_r <= dbgbk_pkg::ST_MEM;
        ready_r <= 1'b0;
      end
    end else if (MEM_ACK) begin                             // R15
      state_r <= dbgbk_pkg::ST_IDLE;
      ready_r <= 1'b1;
    end
  end

  // Memory request, held until acknowledged
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      mem_req_r   <= 1'b0;
      mem_write_r <= 1'b0;
      mem_addr_r  <= dbgbk_pkg::ADDR_RST;
      mem_size_r  <= dbgbk_pkg::SIZE_WORD;
      mem_wdata_r <= dbgbk_pkg::WDATA_RST;
      mem_dw_rd_r <= 1'b0;
    end else begin
      case (state_r)
        dbgbk_pkg::ST_IDLE: begin
          if (take && go_mem) begin
            mem_req_r   <= 1'b1;
            mem_write_r <= REQ_WRITE;
            mem_addr_r  <= win_addr(TRANSFER_ADDRESS, idx, dw); // R10
            mem_size_r  <= dw ? dbgbk_pkg::SIZE_DWORD
                              : dbgbk_pkg::SIZE_WORD;
            mem_dw_rd_r <= dw && !REQ_WRITE;
            if (dw) begin
              mem_wdata_r <= {REQ_WDATA, pend_word_r};      // R16
            end else begin
              mem_wdata_r <= {32'h0000_0000, REQ_WDATA};    // R19
            end
          end
        end
        dbgbk_pkg::ST_MEM: begin
          if (MEM_ACK) begin
            mem_req_r <= 1'b0;
          end
        end
        default: begin
          mem_req_r <= 1'b0;
        end
      endcase
    end
  end

  // Port answer: one-cycle done with read data
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rsp_done_r  <= 1'b0;
      rsp_rdata_r <= dbgbk_pkg::RDATA_RST;
    end else begin
      rsp_done_r <= 1'b0;
      if (state_r == dbgbk_pkg::ST_MEM && MEM_ACK) begin
        rsp_done_r  <= 1'b1;                                // R15
        rsp_rdata_r <= mem_write_r ? dbgbk_pkg::RDATA_RST
                                   : MEM_RDATA[31:0];       // R16 R19
      end else if (take && !go_mem) begin
        rsp_done_r <= 1'b1;
        if (REQ_WRITE) begin
          rsp_rdata_r <= dbgbk_pkg::RDATA_RST;
        end else if (second_half && pair_ok) begin
          rsp_rdata_r <= pend_word_r;                       // R23
        end else if (is_win) begin
          // Out-of-order pair access: defined as zero, no memory access
          rsp_rdata_r <= dbgbk_pkg::RDATA_RST;
        end else begin
          rsp_rdata_r <= ptr_read(REQ_ADDR);                // R20
        end
      end
    end
  end

  // Doubleword pair tracking; a control-word access ends the sequence
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pend_r      <= 1'b0;
      pend_pair_r <= 1'b0;
      pend_rd_r   <= 1'b0;
      pend_word_r <= dbgbk_pkg::RDATA_RST;
    end else if (CONTROL_STATUS_TOUCH) begin
      pend_r <= 1'b0;                                       // R22
    end else if (state_r == dbgbk_pkg::ST_MEM && MEM_ACK) begin
      if (mem_dw_rd_r) begin
        pend_r      <= 1'b1;
        pend_word_r <= MEM_RDATA[63:32];                    // R23
      end
    end else if (take && is_win) begin
      pend_r      <= first_half;
      pend_pair_r <= idx[1];
      pend_rd_r   <= !REQ_WRITE;
      if (first_half && REQ_WRITE) begin
        pend_word_r <= REQ_WDATA;                           // R16 R22
      end
    end
  end

  assign REQ_READY = ready_r;
  assign RSP_DONE  = rsp_done_r;
  assign RSP_RDATA = rsp_rdata_r;
  assign MEM_REQ   = mem_req_r;
  assign MEM_WRITE = mem_write_r;
  assign MEM_ADDR  = mem_addr_r;
  assign MEM_SIZE  = mem_size_r;
  assign MEM_WDATA = mem_wdata_r;

  // Checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);

  sequence s_rd_lower;
    take && !REQ_WRITE && REQ_ADDR == dbgbk_pkg::OFS_PTR_LOWER;
  endsequence

  sequence s_rd_upper;
    take && !REQ_WRITE && REQ_ADDR == dbgbk_pkg::OFS_PTR_UPPER;
  endsequence

  sequence s_word_win;
    take && is_win && !dw;
  endsequence

  sequence s_mem_wait;
    MEM_REQ && !MEM_ACK;
  endsequence

  a_format_bit: assert property (s_rd_lower |=> RSP_DONE // R1
    && RSP_RDATA[dbgbk_pkg::PTR_FORMAT_BIT])
    else $error("pointer format bit not one");

  a_address_field: assert property (s_rd_lower |=> // R2
    RSP_RDATA[31:12] == BASE_EFF[31:12])
    else $error("pointer address field wrong");

  a_upper_narrow: assert property ((s_rd_upper and !LARGE_ADDR) // R3
    |=> RSP_DONE && RSP_RDATA == 32'h0000_0000)
    else $error("upper pointer word not zero");

  a_reserved_bits: assert property (s_rd_lower |=> // R4
    RSP_RDATA[11:2] == 10'h000)
    else $error("pointer reserved bits not zero");

  a_present_flag: assert property (s_rd_lower |=> // R5
    RSP_RDATA[0] == ENTRY_PRESENT)
    else $error("present flag wrong");

  a_dedicated_top: assert property ((s_rd_lower // R21
    and (DEDICATED && !LARGE_ADDR)) |=> RSP_RDATA[31])
    else $error("dedicated link top bit clear");

  a_window_addr: assert property (s_word_win |=> MEM_REQ // R12
    && MEM_ADDR[31:0] == {$past(TRANSFER_ADDRESS[31:4]),
                          $past(REQ_ADDR[3:2]), 2'h0}
    && MEM_ADDR[63:32] == (LARGE_ADDR ? $past(TRANSFER_ADDRESS[63:32])
                                      : 32'h0000_0000))
    else $error("window memory address wrong");

  a_addr_align: assert property (MEM_REQ |-> // R14
    (MEM_SIZE == dbgbk_pkg::SIZE_WORD && MEM_ADDR[1:0] == 2'h0)
    || (MEM_SIZE == dbgbk_pkg::SIZE_DWORD && MEM_ADDR[2:0] == 3'h0))
    else $error("memory address misaligned");

  a_done_after_mem: assert property (s_mem_wait |-> !RSP_DONE // R15
    ##1 (MEM_REQ && $stable(MEM_ADDR)))
    else $error("port done before memory access");

  a_done_on_ack: assert property (MEM_REQ && MEM_ACK |=> // R15
    RSP_DONE && !MEM_REQ && REQ_READY)
    else $error("no done after memory ack");

  a_first_write: assert property (take && first_half && REQ_WRITE // R22
    |=> RSP_DONE && !MEM_REQ)
    else $error("first half write reached memory");

  a_dw_write_order: assert property (take && second_half && REQ_WRITE // R16
    && pair_ok |=> MEM_REQ && MEM_WDATA[63:32] == $past(REQ_WDATA))
    else $error("doubleword write word order wrong");

  a_second_read: assert property (take && second_half && !REQ_WRITE // R23
    && pair_ok |=> RSP_DONE && !MEM_REQ ##1 !MEM_REQ)
    else $error("second half read reached memory");

  a_word_wdata: assert property (take && is_win && !dw && REQ_WRITE // R19
    |=> MEM_REQ && MEM_WDATA[31:0] == $past(REQ_WDATA))
    else $error("word write data wrong");

  a_ptr_no_mem: assert property (take && !is_win // R20
    |=> RSP_DONE && !MEM_REQ)
    else $error("pointer access reached memory");

  a_dw_read_low: assert property (MEM_REQ && MEM_ACK && !MEM_WRITE // R16
    && MEM_SIZE == dbgbk_pkg::SIZE_DWORD
    |=> RSP_RDATA == $past(MEM_RDATA[31:0]))
    else $error("doubleword low word wrong");

endmodule

`default_nettype wire

/* verif/dbgbk_mem_model.sv */
// Memory-side partner for the banked windows: acks after a set stall.
// Assumes request fields held steady until the acking edge, same clock.

`timescale 1ns/100ps
`default_nettype none

module dbgbk_mem_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // Requests from the block
  input  wire logic        mem_req,
  input  wire logic        mem_write,
  input  wire logic [63:0] mem_addr,
  input  wire logic [2:0]  mem_size,
  input  wire logic [63:0] mem_wdata,
  // Answers
  output logic             mem_ack,
  output logic [63:0]      mem_rdata,
  // Stall length in cycles
  input  wire logic [3:0]  wait_cycles
);
  logic [3:0]  cnt_r;
  int          n_req;
  logic        last_write;
  logic [63:0] last_addr;
  logic [2:0]  last_size;
  logic [63:0] last_wdata;

  // Data toggles outside an ack so a stale value never passes for valid
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= 4'h0;
      mem_ack <= 1'b0;
      mem_rdata <= 64'h0;
    end else if (mem_req && !mem_ack && cnt_r == wait_cycles) begin
      mem_ack <= 1'b1;
      mem_rdata <= {mem_addr[31:0] ^ 32'hffff_0000, mem_addr[31:0] + 32'h1};
    end else begin
      cnt_r <= (mem_req && !mem_ack) ? cnt_r + 4'h1 : 4'h0;
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
    end
  end

  // Transfer counted at the edge where the block sees the ack
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      n_req <= 0;
    end else if (mem_req && mem_ack) begin
      n_req <= n_req + 1;
      last_write <= mem_write;
      last_addr <= mem_addr;
      last_size <= mem_size;
      last_wdata <= mem_wdata;
    end
  end
endmodule

`default_nettype wire

/* verif/dbgbk_top_bench.sv */
// Bench for the pointer words and banked windows, wide and narrow address.
// Assumes the memory partner model; inputs driven on falling edges.

`timescale 1ns/100ps
`default_nettype none

module dbgbk_top_bench;
  localparam logic [63:0] BASE   = 64'h0000_0001_c00a_5000;
  localparam logic [63:0] BASE_N = 64'h0000_0000_400a_5000;
  localparam logic [63:0] XFER   = 64'h0000_0012_3456_789b;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        req_valid = 1'b0;
  logic        req_write = 1'b0;
  logic [7:0]  req_addr = 8'h00;
  logic [31:0] req_wdata = 32'h0;
  logic        req_ready;
  logic        rsp_done;
  logic [31:0] rsp_rdata;
  logic [63:0] xfer = XFER;
  logic [2:0]  size = 3'h2;
  logic        touch = 1'b0;
  logic        mreq, mwr, mack;
  logic [63:0] maddr, mwdata, mrdata;
  logic [2:0]  msize;
  logic [3:0]  stall = 4'h0;
  logic        ready_n, done_n, mreq_n, mwr_n, mack_n;
  logic [31:0] rdata_n;
  logic [31:0] rd_narrow;
  logic [63:0] maddr_n, mwdata_n, mrdata_n;
  logic [2:0]  msize_n;
  int          mismatches = 0;
  int          n_tests = 0;

  always #25 clk = ~clk;

  dbgbk_top #(.BASE_ADDR(BASE)) DUT (
    .CLK(clk), .ARST_N(arst_n), .REQ_VALID(req_valid),
    .REQ_WRITE(req_write), .REQ_ADDR(req_addr), .REQ_WDATA(req_wdata),
    .REQ_READY(req_ready), .RSP_DONE(rsp_done), .RSP_RDATA(rsp_rdata),
    .TRANSFER_ADDRESS(xfer), .ACCESS_SIZE(size),
    .CONTROL_STATUS_TOUCH(touch), .MEM_REQ(mreq), .MEM_WRITE(mwr),
    .MEM_ADDR(maddr), .MEM_SIZE(msize), .MEM_WDATA(mwdata),
    .MEM_ACK(mack), .MEM_RDATA(mrdata));

  dbgbk_mem_model MEM (
    .clk(clk), .arst_n(arst_n), .mem_req(mreq), .mem_write(mwr),
    .mem_addr(maddr), .mem_size(msize), .mem_wdata(mwdata),
    .mem_ack(mack), .mem_rdata(mrdata), .wait_cycles(stall));

  // Narrow address, dedicated link, no debug entry; same stimulus
  dbgbk_top #(.LARGE_ADDR(1'b0), .DEDICATED(1'b1), .ENTRY_PRESENT(1'b0),
              .BASE_ADDR(BASE_N)) DUT_NARROW (
    .CLK(clk), .ARST_N(arst_n), .REQ_VALID(req_valid),
    .REQ_WRITE(req_write), .REQ_ADDR(req_addr), .REQ_WDATA(req_wdata),
    .REQ_READY(ready_n), .RSP_DONE(done_n), .RSP_RDATA(rdata_n),
    .TRANSFER_ADDRESS(xfer), .ACCESS_SIZE(size),
    .CONTROL_STATUS_TOUCH(touch), .MEM_REQ(mreq_n), .MEM_WRITE(mwr_n),
    .MEM_ADDR(maddr_n), .MEM_SIZE(msize_n), .MEM_WDATA(mwdata_n),
    .MEM_ACK(mack_n), .MEM_RDATA(mrdata_n));

  dbgbk_mem_model MEM_NARROW (
    .clk(clk), .arst_n(arst_n), .mem_req(mreq_n), .mem_write(mwr_n),
    .mem_addr(maddr_n), .mem_size(msize_n), .mem_wdata(mwdata_n),
    .mem_ack(mack_n), .mem_rdata(mrdata_n), .wait_cycles(stall));

  task automatic finish_test();
    $display("checks %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One register access; called on a falling edge, returns on one
  task automatic acc(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output int lat);
    chk({62'h0, req_ready, ready_n}, 64'h3);
    req_valid = 1'b1;
    req_write = wr;
    req_addr = a;
    req_wdata = wd;
    @(negedge clk);
    req_valid = 1'b0;
    // Done of a register-only access stands right after the taking edge
    for (lat = 1; lat < 60 && rsp_done !== 1'b1; lat++) begin
      @(negedge clk);
    end
    if (lat == 60) begin
      mismatches++;
      finish_test();
    end
    chk({63'h0, done_n}, 64'h1);
    rd = rsp_rdata;
    rd_narrow = rdata_n;
    // Let an edge pass so the next request never reuses this time step
    @(negedge clk);
  endtask

  // Memory expectations after one completed transfer
  task automatic chk_mem(input logic w, input logic [63:0] a,
                         input logic [2:0] s, input int n);
    chk(64'(MEM.n_req), 64'(n));
    chk({63'h0, MEM.last_write}, {63'h0, w});
    chk(MEM.last_addr, a);
    chk({61'h0, MEM.last_size}, {61'h0, s});
  endtask

  task automatic t_pointer();
    logic [31:0] rd;
    int lat;
    acc(1'b1, 8'hf8, 32'hffff_ffff, rd, lat);
    acc(1'b0, 8'hf8, 32'h0, rd, lat);
    chk(64'(rd), 64'({BASE[31:12], 10'h000, 2'b11}));
    chk({63'h0, rd == 32'hffff_ffff}, 64'h0);
    chk(64'(rd_narrow), 64'({1'b1, BASE_N[30:12], 10'h000, 2'b10}));
    acc(1'b0, 8'hf0, 32'h0, rd, lat);
    chk(64'(rd), 64'(BASE[63:32]));
    chk(64'(rd_narrow), 64'h0);
    acc(1'b0, 8'h44, 32'h0, rd, lat);
    chk(64'(rd), 64'h0);
    chk(64'(MEM.n_req), 64'h0);
    $display("test pointer done");
  endtask

  // Word reads of all four windows with growing stalls, then a write
  task automatic t_word();
    logic [31:0] rd;
    logic [63:0] a;
    int lat, n;
    size = 3'h2;
    for (int i = 0; i < 4; i++) begin
      stall = 4'(3 * i);
      n = MEM.n_req;
      a = {XFER[63:4], 4'h0} + 64'(4 * i);
      acc(1'b0, 8'h10 + 8'(4 * i), 32'h0, rd, lat);
      chk_mem(1'b0, a, 3'h2, n + 1);
      chk(MEM_NARROW.last_addr, {32'h0, a[31:0]});
      chk(64'(rd), 64'(a[31:0] + 32'h1));
      chk({63'h0, lat > 3 * i + 1}, 64'h1);
    end
    acc(1'b1, 8'h1c, 32'hcafe_0123, rd, lat);
    chk_mem(1'b1, {XFER[63:4], 4'hc}, 3'h2, n + 2);
    chk(64'(MEM.last_wdata[31:0]), 64'hcafe_0123);
    acc(1'b0, 8'h10, 32'h0, rd, lat);
    chk_mem(1'b0, {XFER[63:4], 4'h0}, 3'h2, n + 3);
    $display("test word done");
  endtask

  // Doubleword pairs: lower window first, same direction
  task automatic t_dword();
    logic [31:0] rd;
    int lat, n;
    size = 3'h3;
    stall = 4'h2;
    n = MEM.n_req;
    acc(1'b0, 8'h10, 32'h0, rd, lat);
    chk_mem(1'b0, {XFER[63:4], 4'h0}, 3'h3, n + 1);
    chk(64'(rd), 64'({XFER[31:4], 4'h0} + 32'h1));
    acc(1'b0, 8'h14, 32'h0, rd, lat);
    chk(64'(rd), 64'({XFER[31:4], 4'h0} ^ 32'hffff_0000));
    chk(64'(MEM.n_req), 64'(n + 1));
    acc(1'b1, 8'h18, 32'h1111_2222, rd, lat);
    chk(64'(MEM.n_req), 64'(n + 1));
    acc(1'b1, 8'h1c, 32'h3333_4444, rd, lat);
    chk_mem(1'b1, {XFER[63:4], 4'h8}, 3'h3, n + 2);
    chk(MEM.last_wdata, 64'h3333_4444_1111_2222);
    $display("test dword done");
  endtask

  // Pair cut short by a control word touch must not write memory
  task automatic t_abort();
    logic [31:0] rd;
    int lat, n;
    n = MEM.n_req;
    acc(1'b1, 8'h10, 32'h5555_aaaa, rd, lat);
    touch = 1'b1;
    @(negedge clk);
    touch = 1'b0;
    acc(1'b1, 8'h14, 32'h6666_bbbb, rd, lat);
    repeat (4) @(negedge clk);
    chk(64'(MEM.n_req), 64'(n));
    $display("test abort done");
  endtask

  initial begin
    repeat (16) @(negedge clk);
    arst_n = 1'b1;
    @(negedge clk);
    t_pointer();
    t_word();
    t_dword();
    t_abort();
    finish_test();
  end
endmodule

`default_nettype wire
